/* File: inc/imustc_regs.svh */
// Functional notes
// RULE_01: accel filter follows rate and bandwidth field; 0xa normal, 0x9 twofold, 0x8 fourfold.
// RULE_02: gyro offers eight selectable rate and bandwidth combinations via a setting.
// RULE_03: host selects widest range, writing 0x03 to range register 0x41, before self-test.
// RULE_04: host then writes 0xac to accel config: continuous filter, averaging, 1.6 kHz.
// RULE_05: after over 2 ms host writes 0x0d to 0x6d, waits over 50 ms, reads axes.
// RULE_06: host writes 0x09 for negative polarity, waits over 50 ms, reads axes again.
// RULE_07: host writes 0x00 to end self-test, then waits over 50 ms to settle.
// RULE_08: pass needs difference at least 1000 mg on x, y and 500 mg on z.
// RULE_09: reset after self-test; otherwise disable, reprogram, wait 50 ms, re-enable interrupts.
// RULE_10: host sets bit 0 to start gyro test; device sets bit 1, result in bit 2.
// RULE_11: gyro background check reads back one in bit 4 when working.
// RULE_12: accel new-data flag bit 7 sets on each new sample and clears by itself; here it clears only when status 0x1d is read.
// RULE_13: accel new-data interrupt maps to either or both accel pins, no enable needed.
// RULE_14: gyro new-data interrupt asserts per new z sample, drops after 280 to 400 us.
// RULE_15: gyro new-data interrupt stays off until 0x80 written; then maps to its pins.
// RULE_16: writing 0xb6 to accel reset command resets the accel part at any time; here ignored while the accel reset delay still runs.
// RULE_17: writing 0xb6 to gyro reset command resets the gyro part at any time; here ignored while the gyro reset delay still runs.
// RULE_18: after soft reset and a delay all settings return to defaults.
// RULE_19: stop-at-full mode stores samples until full, then refuses new ones.
// RULE_20: stream mode overwrites the oldest sample with the newest once full.
// RULE_21: bit 0 of 0x48 picks buffer mode; zero stream (default), one stop-at-full.
// RULE_22: accel starts suspended; host writes 0x04 to power control for normal mode.
// RULE_23: gyro done and fail bits hold until a new trigger or a reset.
`ifndef IMUSTC_REGS_SVH
`define IMUSTC_REGS_SVH
// accel map
`define IMUSTC_A_INT_STAT   8'h1d
`define IMUSTC_A_CONFIG     8'h40
`define IMUSTC_A_RANGE      8'h41
`define IMUSTC_A_FIFO_MODE  8'h48
`define IMUSTC_A_FIFO_CFG   8'h49
`define IMUSTC_A_INT_MAP    8'h58
`define IMUSTC_A_SELFTEST   8'h6d
`define IMUSTC_A_PWR        8'h7d
`define IMUSTC_A_RESET      8'h7e
// gyro map
`define IMUSTC_G_BW         8'h10
`define IMUSTC_G_RESET      8'h14
`define IMUSTC_G_INT_CTRL   8'h15
`define IMUSTC_G_INT_MAP    8'h18
`define IMUSTC_G_BIST       8'h3c
// fields and codes
`define IMUSTC_BWP_NORMAL   4'ha
`define IMUSTC_BWP_TWOFOLD  4'h9
`define IMUSTC_BWP_FOURFOLD 4'h8
`define IMUSTC_DRDY_BIT     7
`define IMUSTC_FIFO_EN_BIT  6
`define IMUSTC_BIST_TRIG    0
`define IMUSTC_BIST_RDY     1
`define IMUSTC_BIST_FAIL    2
`define IMUSTC_BIST_BG      4
`define IMUSTC_CMD_SOFTRST  8'hb6
`define IMUSTC_CMD_FIFORST  8'hb0
`define IMUSTC_PWR_NORMAL   8'h04
`define IMUSTC_G_DRDY_EN    8'h80
// reset values
`define IMUSTC_RST_CONFIG   8'ha8
`define IMUSTC_RST_RANGE    8'h01
`define IMUSTC_RST_ZERO     8'h00
// timing
`define IMUSTC_CLK_MHZ      100
`define IMUSTC_DRDY_MIN_US  280
`define IMUSTC_DRDY_MAX_US  400
`define IMUSTC_A_BOOT_US    1000
`define IMUSTC_G_BOOT_US    30000
`define IMUSTC_BIST_US      10
`define IMUSTC_US_TO_CYC(us) ((us) * `IMUSTC_CLK_MHZ)
`define IMUSTC_FIFO_DEPTH   146
`endif

/* File: inc/imustc_pkg.sv */
package imustc_pkg;
  typedef enum logic [1:0] {OSR_NORMAL, OSR_TWOFOLD, OSR_FOURFOLD, OSR_RESERVED} imustc_osr_e;
  typedef enum logic [1:0] {BIST_IDLE, BIST_RUN, BIST_DONE} imustc_bist_e;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       gyro;
    logic [7:0] addr;
    logic [7:0] wdata;
  } imustc_req_s;
  typedef struct packed {
    logic [15:0] x;
    logic [15:0] y;
    logic [15:0] z;
  } imustc_sample_s;
  typedef struct packed {
    imustc_osr_e oversample;
    logic [3:0]  output_data_rate;
  } imustc_filt_s;
endpackage : imustc_pkg

/* File: core/imustc_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
`include "imustc_regs.svh"
module imustc_ctrl #(
  parameter int unsigned DRDY_HOLD_CYC = `IMUSTC_US_TO_CYC(`IMUSTC_DRDY_MIN_US),
  parameter int unsigned A_BOOT_CYC    = `IMUSTC_US_TO_CYC(`IMUSTC_A_BOOT_US),
  parameter int unsigned G_BOOT_CYC    = `IMUSTC_US_TO_CYC(`IMUSTC_G_BOOT_US)
) (
  // clock and reset
  input  wire logic                   clock,
  input  wire logic                   rst,
  // register access from the serial front end
  input  wire imustc_pkg::imustc_req_s req,
  output var  logic [7:0]             rdata,
  output var  logic                   rvalid,
  // sensor datapath events
  input  wire logic                   accel_sample_done,
  input  wire imustc_pkg::imustc_sample_s accel_sample,
  input  wire logic                   gyro_z_stored,
  input  wire logic                   gyro_bist_fault,
  input  wire logic                   gyro_bg_ok,
  // accel buffer read side
  input  wire logic                   fifo_pop,
  output var  imustc_pkg::imustc_sample_s fifo_rdata,
  output var  logic                   fifo_rvalid,
  output var  logic [7:0]             fifo_level,
  output var  logic [7:0]             fifo_skipped,
  // interrupt pins
  output var  logic                   accel_irq_pin_a,
  output var  logic                   accel_irq_pin_b,
  output var  logic                   gyro_irq_pin_a,
  output var  logic                   gyro_irq_pin_b,
  // analog control
  output var  imustc_pkg::imustc_filt_s accel_filter,
  output var  logic [1:0]             accel_range_sel,
  output var  logic                   accel_st_enable,
  output var  logic                   accel_st_positive,
  output var  logic                   accel_normal_mode,
  output var  logic [2:0]             gyro_bw_sel,
  output var  logic                   gyro_bist_run,
  output var  logic                   accel_booting,
  output var  logic                   gyro_booting
);
  import imustc_pkg::*;

  localparam int unsigned BIST_CYC = `IMUSTC_US_TO_CYC(`IMUSTC_BIST_US);
  localparam int unsigned DEPTH    = `IMUSTC_FIFO_DEPTH;

  function automatic imustc_osr_e osr_decode(input logic [3:0] bwp);
    case (bwp)
      `IMUSTC_BWP_NORMAL: osr_decode = OSR_NORMAL;
      `IMUSTC_BWP_TWOFOLD:  osr_decode = OSR_TWOFOLD;
      `IMUSTC_BWP_FOURFOLD: osr_decode = OSR_FOURFOLD;
      default:            osr_decode = OSR_RESERVED;
    endcase
  endfunction : osr_decode

  function automatic logic [7:0] ptr_inc(input logic [7:0] p);
    ptr_inc = (p == 8'(DEPTH - 1)) ? 8'h00 : p + 8'h01;
  endfunction : ptr_inc

  // ----------------------------------------
  // decode
  // ----------------------------------------
  logic        a_wr;
  logic        g_wr;
  logic [31:0] a_boot_reg;
  logic [31:0] g_boot_reg;
  logic        a_apply;
  logic        g_apply;
  assign a_wr    = req.wr && !req.gyro && a_boot_reg == 32'h0;
  assign g_wr    = req.wr && req.gyro && g_boot_reg == 32'h0;
  assign a_apply = a_boot_reg == 32'h1;
  assign g_apply = g_boot_reg == 32'h1;

  // ----------------------------------------
  // soft reset delays
  // ----------------------------------------
  // register contents stay until the delay ends, then defaults load
  always_ff @(posedge clock)
  begin
    if (rst)
      a_boot_reg <= 32'h0;
    else if (a_wr && req.addr == `IMUSTC_A_RESET && req.wdata == `IMUSTC_CMD_SOFTRST) // [RULE_16]
      a_boot_reg <= A_BOOT_CYC;
    else if (a_boot_reg != 32'h0)
      a_boot_reg <= a_boot_reg - 32'h1;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      g_boot_reg <= 32'h0;
    else if (g_wr && req.addr == `IMUSTC_G_RESET && req.wdata == `IMUSTC_CMD_SOFTRST) // [RULE_17]
      g_boot_reg <= G_BOOT_CYC;
    else if (g_boot_reg != 32'h0)
      g_boot_reg <= g_boot_reg - 32'h1;
  end

  always_ff @(posedge clock)
  begin
    accel_booting <= !rst && a_boot_reg != 32'h0;
    gyro_booting  <= !rst && g_boot_reg != 32'h0;
  end

  // ----------------------------------------
  // accel configuration
  // ----------------------------------------
  logic [7:0] a_config_reg;
  logic [7:0] a_range_reg;
  logic [7:0] a_st_reg;
  logic [7:0] a_pwr_reg;
  logic [7:0] a_map_reg;
  logic       a_fifo_stop_reg;
  logic       a_fifo_en_reg;
  always_ff @(posedge clock)
  begin
    if (rst || a_apply) // [RULE_18]
    begin
      a_config_reg    <= `IMUSTC_RST_CONFIG;
      a_range_reg     <= `IMUSTC_RST_RANGE;
      a_st_reg        <= `IMUSTC_RST_ZERO;
      a_pwr_reg       <= `IMUSTC_RST_ZERO; // [RULE_22]
      a_map_reg       <= `IMUSTC_RST_ZERO;
      a_fifo_stop_reg <= 1'b0; // [RULE_21]
      a_fifo_en_reg   <= 1'b0;
    end
    else if (a_wr)
    begin
      case (req.addr)
        `IMUSTC_A_CONFIG:    a_config_reg    <= req.wdata;
        `IMUSTC_A_RANGE:     a_range_reg     <= {6'h00, req.wdata[1:0]};
        `IMUSTC_A_SELFTEST:  a_st_reg        <= req.wdata;
        `IMUSTC_A_PWR:       a_pwr_reg       <= req.wdata;
        `IMUSTC_A_INT_MAP:   a_map_reg       <= req.wdata;
        `IMUSTC_A_FIFO_MODE: a_fifo_stop_reg <= req.wdata[0]; // [RULE_21]
        `IMUSTC_A_FIFO_CFG:  a_fifo_en_reg   <= req.wdata[`IMUSTC_FIFO_EN_BIT];
        default:             a_config_reg    <= a_config_reg;
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    accel_filter.oversample       <= osr_decode(a_config_reg[7:4]); // [RULE_01]
    accel_filter.output_data_rate <= a_config_reg[3:0]; // [RULE_01]
    accel_range_sel               <= a_range_reg[1:0];
    accel_st_enable               <= a_st_reg[0];
    accel_st_positive             <= a_st_reg[2];
    accel_normal_mode             <= a_pwr_reg == `IMUSTC_PWR_NORMAL;
  end

  // ----------------------------------------
  // accel new-data flag and pins
  // ----------------------------------------
  // flag clears when status is read; a sample in the same cycle wins
  logic a_drdy_reg;
  logic a_stat_rd;
  assign a_stat_rd = req.rd && !req.gyro && req.addr == `IMUSTC_A_INT_STAT;
  always_ff @(posedge clock)
  begin
    if (rst || a_apply)
      a_drdy_reg <= 1'b0;
    else if (accel_sample_done)
      a_drdy_reg <= 1'b1; // [RULE_12]
    else if (a_stat_rd)
      a_drdy_reg <= 1'b0; // [RULE_12]
  end

  always_ff @(posedge clock)
  begin
    accel_irq_pin_a <= !rst && a_drdy_reg && a_map_reg[2]; // [RULE_13]
    accel_irq_pin_b <= !rst && a_drdy_reg && a_map_reg[6]; // [RULE_13]
  end

  // ----------------------------------------
  // accel sample buffer
  // ----------------------------------------
  imustc_sample_s mem [DEPTH];
  logic [7:0] wr_ptr_reg;
  logic [7:0] rd_ptr_reg;
  logic [7:0] count_reg;
  logic       full;
  logic       push;
  logic       pop;
  logic       flush;
  assign full  = count_reg == 8'(DEPTH);
  assign push  = accel_sample_done && a_fifo_en_reg && !(full && a_fifo_stop_reg); // [RULE_19]
  assign pop   = fifo_pop && count_reg != 8'h00;
  assign flush = a_wr && req.addr == `IMUSTC_A_RESET && req.wdata == `IMUSTC_CMD_FIFORST;

  always_ff @(posedge clock)
  begin
    if (push)
      mem[wr_ptr_reg] <= accel_sample;
  end

  always_ff @(posedge clock)
  begin
    if (rst || a_apply || flush)
    begin
      wr_ptr_reg   <= 8'h00;
      rd_ptr_reg   <= 8'h00;
      count_reg    <= 8'h00;
      fifo_skipped <= 8'h00;
    end
    else
    begin
      if (push)
        wr_ptr_reg <= ptr_inc(wr_ptr_reg);
      // oldest entry dropped when a push meets a full stream buffer
      if (pop || (push && full))
        rd_ptr_reg <= ptr_inc(rd_ptr_reg); // [RULE_20]
      if (push && !full && !pop)
        count_reg <= count_reg + 8'h01;
      else if (pop && !push)
        count_reg <= count_reg - 8'h01;
      if (accel_sample_done && a_fifo_en_reg && full && !pop && fifo_skipped != 8'hff)
        fifo_skipped <= fifo_skipped + 8'h01;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      fifo_rdata <= '0;
    else if (pop)
      fifo_rdata <= mem[rd_ptr_reg];
    fifo_rvalid <= !rst && pop;
    fifo_level  <= rst ? 8'h00 : count_reg;
  end

  // ----------------------------------------
  // gyro configuration
  // ----------------------------------------
  logic [2:0] g_bw_reg;
  logic [7:0] g_int_ctrl_reg;
  logic [7:0] g_map_reg;
  always_ff @(posedge clock)
  begin
    if (rst || g_apply) // [RULE_18]
    begin
      g_bw_reg       <= 3'h0;
      g_int_ctrl_reg <= `IMUSTC_RST_ZERO; // [RULE_15]
      g_map_reg      <= `IMUSTC_RST_ZERO;
    end
    else if (g_wr)
    begin
      case (req.addr)
        `IMUSTC_G_BW:       g_bw_reg       <= req.wdata[2:0]; // [RULE_02]
        `IMUSTC_G_INT_CTRL: g_int_ctrl_reg <= req.wdata;
        `IMUSTC_G_INT_MAP:  g_map_reg      <= req.wdata;
        default:            g_bw_reg       <= g_bw_reg;
      endcase
    end
  end

  always_ff @(posedge clock)
    gyro_bw_sel <= g_bw_reg; // [RULE_02]

  // ----------------------------------------
  // gyro new-data pulse
  // ----------------------------------------
  // held for the least documented time so it always ends inside the window
  logic [31:0] g_drdy_cnt_reg;
  logic        g_drdy_en;
  assign g_drdy_en = g_int_ctrl_reg == `IMUSTC_G_DRDY_EN;
  always_ff @(posedge clock)
  begin
    if (rst || g_apply || !g_drdy_en)
      g_drdy_cnt_reg <= 32'h0; // [RULE_15]
    else if (gyro_z_stored)
      g_drdy_cnt_reg <= DRDY_HOLD_CYC; // [RULE_14]
    else if (g_drdy_cnt_reg != 32'h0)
      g_drdy_cnt_reg <= g_drdy_cnt_reg - 32'h1; // [RULE_14]
  end

  always_ff @(posedge clock)
  begin
    gyro_irq_pin_a <= !rst && g_drdy_cnt_reg != 32'h0 && g_map_reg[0]; // [RULE_15]
    gyro_irq_pin_b <= !rst && g_drdy_cnt_reg != 32'h0 && g_map_reg[5]; // [RULE_15]
  end

  // ----------------------------------------
  // gyro built-in test
  // ----------------------------------------
  imustc_bist_e bist_state_reg;
  logic [31:0]  bist_cnt_reg;
  logic         bist_fail_reg;
  logic         bist_trig;
  assign bist_trig = g_wr && req.addr == `IMUSTC_G_BIST && req.wdata[`IMUSTC_BIST_TRIG];
  always_ff @(posedge clock)
  begin
    if (rst || g_apply)
    begin
      bist_state_reg <= BIST_IDLE;
      bist_cnt_reg   <= 32'h0;
      bist_fail_reg  <= 1'b0;
    end
    else
    begin
      case (bist_state_reg)
        BIST_IDLE, BIST_DONE:
        begin
          if (bist_trig) // [RULE_10]
          begin
            bist_state_reg <= BIST_RUN;
            bist_cnt_reg   <= BIST_CYC;
            bist_fail_reg  <= 1'b0; // [RULE_23]
          end
        end
        BIST_RUN:
        begin
          bist_cnt_reg <= bist_cnt_reg - 32'h1;
          if (gyro_bist_fault)
            bist_fail_reg <= 1'b1; // [RULE_10]
          if (bist_cnt_reg == 32'h1)
            bist_state_reg <= BIST_DONE; // [RULE_10]
        end
        default: bist_state_reg <= BIST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock)
    gyro_bist_run <= !rst && bist_state_reg == BIST_RUN;

  // ----------------------------------------
  // read data
  // ----------------------------------------
  logic [7:0] rd_mux;
  always_comb
  begin
    rd_mux = 8'h00;
    if (req.gyro)
    begin
      case (req.addr)
        `IMUSTC_G_BW:       rd_mux = {5'h00, g_bw_reg};
        `IMUSTC_G_INT_CTRL: rd_mux = g_int_ctrl_reg;
        `IMUSTC_G_INT_MAP:  rd_mux = g_map_reg;
        `IMUSTC_G_BIST:     rd_mux = {3'h0, gyro_bg_ok, 1'b0, bist_fail_reg, // [RULE_11]
                                      bist_state_reg == BIST_DONE, 1'b0};    // [RULE_23]
        default:            rd_mux = 8'h00;
      endcase
    end
    else
    begin
      case (req.addr)
        `IMUSTC_A_INT_STAT:  rd_mux = {a_drdy_reg, 7'h00};
        `IMUSTC_A_CONFIG:    rd_mux = a_config_reg;
        `IMUSTC_A_RANGE:     rd_mux = a_range_reg;
        `IMUSTC_A_FIFO_MODE: rd_mux = {7'h00, a_fifo_stop_reg};
        `IMUSTC_A_FIFO_CFG:  rd_mux = {1'b0, a_fifo_en_reg, 6'h00};
        `IMUSTC_A_INT_MAP:   rd_mux = a_map_reg;
        `IMUSTC_A_SELFTEST:  rd_mux = a_st_reg;
        `IMUSTC_A_PWR:       rd_mux = a_pwr_reg;
        default:             rd_mux = 8'h00;
      endcase
    end
  end

  // a part that is still booting answers zero
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      rdata  <= 8'h00;
      rvalid <= 1'b0;
    end
    else
    begin
      rvalid <= req.rd;
      if (req.rd)
        rdata <= ((req.gyro ? g_boot_reg : a_boot_reg) != 32'h0) ? 8'h00 : rd_mux;
    end
  end
endmodule : imustc_ctrl
`default_nettype wire

/* File: verif/imustc_ctrl_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module imustc_ctrl_properties #(
  parameter int unsigned DRDY_HOLD_CYC = 28000,
  parameter int unsigned A_BOOT_CYC    = 100000,
  parameter int unsigned G_BOOT_CYC    = 3000000
) (
  // clock and reset
  input wire logic                     clock,
  input wire logic                     rst,
  // register side
  input wire imustc_pkg::imustc_req_s  req,
  input wire logic                     rvalid,
  // events and buffer
  input wire logic                     accel_sample_done,
  input wire logic                     fifo_pop,
  input wire logic                     fifo_rvalid,
  input wire logic [7:0]               fifo_level,
  // pins and controls
  input wire logic                     accel_irq_pin_a,
  input wire logic                     gyro_irq_pin_a,
  input wire imustc_pkg::imustc_filt_s accel_filter,
  input wire logic                     gyro_bist_run,
  input wire logic                     accel_booting
);
  localparam int unsigned BIST_CYC = 1000;
  logic [31:0] pin_cnt_reg;
  logic [31:0] run_cnt_reg;
  logic [31:0] boot_cnt_reg;
  // ----
  // high-time counters
  // ----
  // a run of n high samples leaves n here on the edge that sees the fall
  always_ff @(posedge clock)
  begin
    pin_cnt_reg <= (rst || !gyro_irq_pin_a) ? 32'h0 : pin_cnt_reg + 32'h1;
    run_cnt_reg <= (rst || !gyro_bist_run) ? 32'h0 : run_cnt_reg + 32'h1;
    boot_cnt_reg <= (rst || !accel_booting) ? 32'h0 : boot_cnt_reg + 32'h1;
  end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  a_read_answer: assert property (
    req.rd |=> rvalid) else $error("read got no answer");
  a_accel_pin_cause: assert property (
    $rose(accel_irq_pin_a) |-> $past(accel_sample_done, 2)) else $error("accel pin rose alone");
  // limitation: a retrigger inside the pulse legally lengthens it
  a_gyro_pin_hold: assert property (
    $fell(gyro_irq_pin_a) |-> pin_cnt_reg == DRDY_HOLD_CYC) else $error("gyro pulse length");
  a_bist_run_len: assert property (
    $fell(gyro_bist_run) |-> run_cnt_reg == BIST_CYC) else $error("test run length");
  a_boot_len: assert property (
    $fell(accel_booting) |-> boot_cnt_reg == A_BOOT_CYC) else $error("boot delay length");
  a_fifo_bound: assert property (
    fifo_level <= 8'h92) else $error("buffer level above depth");
  a_fifo_answer: assert property (
    fifo_pop && fifo_level != 8'h00 |=> fifo_rvalid) else $error("pop got no data");
  a_rate_follow: assert property (
    req.wr && !req.gyro && req.addr == 8'h40 && !accel_booting
    |-> ##2 accel_filter.output_data_rate == $past(req.wdata[3:0], 2))
    else $error("rate field not applied");
endmodule : imustc_ctrl_properties
bind imustc_ctrl imustc_ctrl_properties #(
  .DRDY_HOLD_CYC (DRDY_HOLD_CYC),
  .A_BOOT_CYC    (A_BOOT_CYC),
  .G_BOOT_CYC    (G_BOOT_CYC)
) u_imustc_ctrl_properties (
  .clock, .rst, .req, .rvalid, .accel_sample_done, .fifo_pop, .fifo_rvalid, .fifo_level,
  .accel_irq_pin_a, .gyro_irq_pin_a, .accel_filter, .gyro_bist_run, .accel_booting
);
`default_nettype wire

/* File: verif/imustc_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module imustc_host_model (
  // clock
  input wire logic                     clock,
  // register requests
  output var imustc_pkg::imustc_req_s  req
);
  import imustc_pkg::*;
  initial req = '0;
  // one byte per access, launched off the falling edge and held one full cycle
  task automatic access(input logic w, input logic g, input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    req = '{wr: w, rd: !w, gyro: g, addr: a, wdata: d};
    @(negedge clock);
    req = '0;
  endtask : access
  // host-side verdict on the self-test swing, each axis given in mg
  function automatic logic st_pass(input int dx, input int dy, input int dz);
    st_pass = dx >= 1000 && dy >= 1000 && dz >= 500;
  endfunction : st_pass
endmodule : imustc_host_model
`default_nettype wire

/* File: verif/imu_selftest_irq_reset_ctrl_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module imu_selftest_irq_reset_ctrl_tb;
  import imustc_pkg::*;
  logic clock = 1'b0, rst = 1'b1, accel_sample_done = 1'b0, gyro_z_stored = 1'b0;
  logic gyro_bist_fault = 1'b0, gyro_bg_ok = 1'b0, fifo_pop = 1'b0, rvalid, fifo_rvalid;
  logic accel_irq_pin_a, accel_irq_pin_b, gyro_irq_pin_a, gyro_irq_pin_b, accel_st_enable;
  logic accel_st_positive, accel_normal_mode, gyro_bist_run, accel_booting, gyro_booting;
  logic [7:0] rdata, fifo_level, fifo_skipped, v, exp_q[$], mask_q[$];
  logic [7:0] st_code[3] = '{8'h0d, 8'h09, 8'h00};
  logic [3:0] bwp[3] = '{4'ha, 4'h9, 4'h8};
  logic [2:0] gyro_bw_sel;
  logic [1:0] accel_range_sel;
  imustc_osr_e osr[3] = '{OSR_NORMAL, OSR_TWOFOLD, OSR_FOURFOLD};
  imustc_req_s req;
  imustc_filt_s accel_filter;
  imustc_sample_s accel_sample = '0, fifo_rdata, smp[150], smp_q[$];
  int n_fail = 0, num_checks = 0;
  initial forever #5 clock = ~clock;
  imustc_host_model u_imustc_host_model (.clock, .req);
  // short counts keep boot and pulse waits within a brief run
  imustc_ctrl #(.DRDY_HOLD_CYC(20), .A_BOOT_CYC(10), .G_BOOT_CYC(10)) u_imustc_ctrl (
    .clock, .rst, .req, .rdata, .rvalid, .accel_sample_done, .accel_sample, .gyro_z_stored,
    .gyro_bist_fault, .gyro_bg_ok, .fifo_pop, .fifo_rdata, .fifo_rvalid, .fifo_level,
    .fifo_skipped, .accel_irq_pin_a, .accel_irq_pin_b, .gyro_irq_pin_a, .gyro_irq_pin_b,
    .accel_filter, .accel_range_sel, .accel_st_enable, .accel_st_positive,
    .accel_normal_mode, .gyro_bw_sel, .gyro_bist_run, .accel_booting, .gyro_booting);
  task automatic wrap_up();
    // an answer that never came leaves its note behind
    if (exp_q.size() != 0 || smp_q.size() != 0)
    begin
      n_fail++;
      $display("unexpected pending_results exp 0 got %0d", exp_q.size() + smp_q.size());
    end
    if (n_fail == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up
  task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("unexpected %s exp %h got %h", what, e, g);
    end
  endtask : chk
  task automatic chk_smp(input imustc_sample_s e, input imustc_sample_s g);
    num_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("unexpected fifo_rdata exp %h got %h", e, g);
    end
  endtask : chk_smp
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask : cyc
  task automatic wr(input logic g, input logic [7:0] a, input logic [7:0] d);
    u_imustc_host_model.access(1'b1, g, a, d);
  endtask : wr
  // masked bits are left to the design's choice
  task automatic rd(input logic g, input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    exp_q.push_back(e & m);
    mask_q.push_back(m);
    u_imustc_host_model.access(1'b0, g, a, 8'h00);
  endtask : rd
  task automatic feed(input int n);
    for (int i = 0; i < n; i++)
    begin
      smp[i] = 48'({$urandom, $urandom});
      accel_sample = smp[i];
      accel_sample_done = 1'b1;
      cyc(1);
      accel_sample_done = 1'b0;
      cyc(1);
    end
  endtask : feed
  task automatic gz();
    gyro_z_stored = 1'b1;
    cyc(1);
    gyro_z_stored = 1'b0;
    cyc(3);
  endtask : gz
  task automatic wait_boot(input logic g);
    int k;
    cyc(3);
    for (k = 0; k < 40 && (g ? gyro_booting : accel_booting) !== 1'b0; k++)
      cyc(1);
    if (k == 40)
    begin
      n_fail++;
      wrap_up();
    end
  endtask : wait_boot
  // ----
  // result monitor
  // ----
  always @(negedge clock)
  begin
    if (rvalid === 1'b1 && exp_q.size() == 0)
      chk("rvalid", 8'h00, 8'h01);
    else if (rvalid === 1'b1)
      chk("rdata", exp_q.pop_front(), rdata & mask_q.pop_front());
    if (fifo_rvalid === 1'b1 && smp_q.size() == 0)
      chk("fifo_rvalid", 8'h00, 8'h01);
    else if (fifo_rvalid === 1'b1)
      chk_smp(smp_q.pop_front(), fifo_rdata);
  end
  // ----
  // main sequence
  // ----
  initial
  begin
    void'($urandom(75));
    cyc(20);
    rst = 1'b0;
    rd(0, 8'h40, 8'ha8, 8'hff);
    rd(0, 8'h41, 8'h01, 8'hff);
    rd(0, 8'h48, 8'h00, 8'h01);
    rd(0, 8'h20, 8'h00, 8'hff);
    wr(0, 8'h7d, 8'h04);
    wr(0, 8'h41, 8'h03);
    wr(0, 8'h40, 8'hac);
    cyc(2);
    chk("normal", 8'h01, 8'(accel_normal_mode));
    chk("range", 8'h03, 8'(accel_range_sel));
    rd(0, 8'h40, 8'hac, 8'hff);
    // the settle waits are the host's business, so a short stand-in suffices
    cyc(200);
    foreach (st_code[i])
    begin
      wr(0, 8'h6d, st_code[i]);
      cyc(2);
      chk("st_en", 8'(st_code[i] != 8'h00), 8'(accel_st_enable));
      chk("st_pos", 8'(st_code[i] == 8'h0d), 8'(accel_st_positive));
      rd(0, 8'h6d, st_code[i], 8'hff);
    end
    chk("st_pass", 8'h01, 8'(u_imustc_host_model.st_pass(1000, 1000, 500)));
    chk("st_pass", 8'h00, 8'(u_imustc_host_model.st_pass(1000, 1000, 499)));
    foreach (bwp[i])
    begin
      wr(0, 8'h40, {bwp[i], 4'hc});
      cyc(2);
      chk("osr", 8'(osr[i]), 8'(accel_filter.oversample));
    end
    repeat (4)
    begin
      v = 8'($urandom_range(7));
      wr(1, 8'h10, v);
      cyc(2);
      chk("gyro_bw", v, 8'(gyro_bw_sel));
    end
    wr(0, 8'h58, 8'h44);
    feed(1);
    cyc(2);
    chk("irq_a", 8'h01, 8'(accel_irq_pin_a));
    chk("irq_b", 8'h01, 8'(accel_irq_pin_b));
    rd(0, 8'h1d, 8'h80, 8'h80);
    rd(0, 8'h1d, 8'h00, 8'h80);
    cyc(2);
    chk("irq_a", 8'h00, 8'(accel_irq_pin_a));
    wr(1, 8'h18, 8'h21);
    gz();
    chk("gyro_irq", 8'h00, 8'(gyro_irq_pin_a));
    wr(1, 8'h15, 8'h80);
    gz();
    chk("gyro_irq_a", 8'h01, 8'(gyro_irq_pin_a));
    chk("gyro_irq_b", 8'h01, 8'(gyro_irq_pin_b));
    cyc(25);
    chk("gyro_irq_a", 8'h00, 8'(gyro_irq_pin_a));
    for (int f = 1; f >= 0; f--)
    begin
      // second pass flips the level so both readings of bit 4 are seen
      gyro_bg_ok = f[0] ? 1'($urandom) : !gyro_bg_ok;
      gyro_bist_fault = f[0];
      wr(1, 8'h3c, 8'h01);
      cyc(3);
      chk("bist_run", 8'h01, 8'(gyro_bist_run));
      cyc(1010);
      gyro_bist_fault = 1'b0;
      repeat (2)
        rd(1, 8'h3c, {3'h0, gyro_bg_ok, 1'b0, f[0], 2'b10}, 8'h16);
    end
    wr(1, 8'h14, 8'hb6);
    wait_boot(1'b1);
    chk("gyro_bw", 8'h00, 8'(gyro_bw_sel));
    rd(1, 8'h15, 8'h00, 8'hff);
    rd(1, 8'h3c, 8'h00, 8'h06);
    wr(0, 8'h49, 8'h40);
    for (int m = 1; m >= 0; m--)
    begin
      wr(0, 8'h7e, 8'hb0);
      wr(0, 8'h48, 8'(m));
      feed(150);
      chk("level", 8'h92, fifo_level);
      if (m == 1)
        chk("skipped", 8'h04, fifo_skipped);
      smp_q.push_back(smp[m == 1 ? 0 : 4]);
      fifo_pop = 1'b1;
      cyc(1);
      fifo_pop = 1'b0;
      cyc(2);
    end
    wr(0, 8'h7e, 8'hb6);
    wait_boot(1'b0);
    rd(0, 8'h40, 8'ha8, 8'hff);
    rd(0, 8'h41, 8'h01, 8'hff);
    rd(0, 8'h48, 8'h00, 8'h01);
    chk("normal", 8'h00, 8'(accel_normal_mode));
    cyc(4);
    wrap_up();
  end
endmodule : imu_selftest_irq_reset_ctrl_tb
`default_nettype wire
